// [design/tccp_top.sv]
// What this block does
// - reverse current: sink gate off, back on after re-enable delay
// - bus undervoltage: sink gate off likewise, back on after re-enable delay
// - unattached: bus discharge pulldown on toward safe zero level
// - source, both open: nothing attached, watch both, no VBUS or VCONN
// - source, Rd on CC1: sink attached, watch CC1, VBUS on, VCONN off
// - source, Rd on CC2: sink attached, watch CC2, VBUS on, VCONN off
// - source, Ra on CC1: cable only, watch CC2 attach, CC1 removal, no power
// - source, Ra on CC2: cable only, watch CC1 attach, CC2 removal, no power
// - Ra CC1 and Rd CC2: VBUS plus VCONN on CC1, watch CC2 only
// - Rd CC1 and Ra CC2: VBUS plus VCONN on CC2, watch CC1 only
// - Rd/Rd is debug accessory, Ra/Ra audio; either pin detaches
// - default pull-up until VBUS switch closes, then firmware level
// - an Ra level on a pin means active cable, not sink
// - detach only after watched pin stays open, or VBUS stays gone as sink, for debounce time
// - sink presents pulldown on both pins and waits for a source
// - sink attaches on VBUS, reports advertised current from CC
// - dual-role alternates pins between pulldown and pull-up
// - dead battery shows Rd until firmware releases it
// - CC overvoltage or 5V reverse current: cable switch and PD tx off
// - both straps converted at power-up, codes readable in the strap register
// - strap ratio decodes to 0..7 by fixed lower bounds
`timescale 1ns/1ns
`default_nettype none
`include "tccp_consts.svh"
module tccp_top
  import tccp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // analog front end
  input  wire tccp_cc_t    cc1_level,
  input  wire tccp_cc_t    cc2_level,
  input  wire tccp_flags_t flags,
  input  wire logic        adc_valid,
  input  wire logic [13:0] adc_ratio,
  output var  logic        adc_sel_two,
  output var  tccp_pwr_t   pwr
);
  // ------------------------------------------------
  // strap decode
  // ------------------------------------------------
  function automatic logic [2:0] strap_decode(input logic [13:0] r);
    logic [2:0] v;
    v = 3'h0;
    if (r >= `TCCP_STRAP_B1) v = 3'h1;
    if (r >= `TCCP_STRAP_B2) v = 3'h2;
    if (r >= `TCCP_STRAP_B3) v = 3'h3;
    if (r >= `TCCP_STRAP_B4) v = 3'h4;
    if (r >= `TCCP_STRAP_B5) v = 3'h5;
    if (r >= `TCCP_STRAP_B6) v = 3'h6;
    if (r >= `TCCP_STRAP_B7) v = 3'h7;
    return v;
  endfunction : strap_decode

  logic [2:0] strap1_reg;
  logic [2:0] strap2_reg;
  logic [1:0] strap_cnt_reg;
  // two conversions after reset, strap one first
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strap1_reg    <= 3'h0;
      strap2_reg    <= 3'h0;
      strap_cnt_reg <= 2'h0;
      adc_sel_two   <= 1'b0;
    end else if (adc_valid && strap_cnt_reg != 2'h2) begin
      if (strap_cnt_reg == 2'h0) begin
        strap1_reg  <= strap_decode(adc_ratio);
        adc_sel_two <= 1'b1;
      end else begin
        strap2_reg  <= strap_decode(adc_ratio);
      end
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end
  wire logic strap_done = (strap_cnt_reg == 2'h2);

  // ------------------------------------------------
  // register file
  // ------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] blkdly_reg;
  logic [31:0] ondly_reg;
  logic [31:0] ccdeb_reg;
  logic [31:0] fastoff_reg;
  logic [31:0] drphalf_reg;
  logic [5:0]  event_reg;
  logic [5:0]  event_set;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [5:0]  ev_clr;

  // address phase capture; slave is zero wait state
  wire logic addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr;
    end
  end

  // writable registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg    <= `TCCP_CTRL_RST;
      blkdly_reg  <= `TCCP_BLKDLY_RST;
      ondly_reg   <= `TCCP_ONDLY_RST;
      ccdeb_reg   <= `TCCP_CCDEB_RST;
      fastoff_reg <= `TCCP_FASTOFF_RST;
      drphalf_reg <= `TCCP_DRPHALF_RST;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        `TCCP_ADDR_CTRL:    ctrl_reg    <= hwdata;
        `TCCP_ADDR_BLKDLY:  blkdly_reg  <= hwdata;
        `TCCP_ADDR_ONDLY:   ondly_reg   <= hwdata;
        `TCCP_ADDR_CCDEB:   ccdeb_reg   <= hwdata;
        `TCCP_ADDR_FASTOFF: fastoff_reg <= hwdata;
        `TCCP_ADDR_DRPHALF: drphalf_reg <= hwdata;
        default: ;
      endcase
    end
  end

  // write-one-to-clear of event bits; hardware set wins
  always_comb begin
    ev_clr = 6'h00;
    if (wr_pend_reg && wr_addr_reg == `TCCP_ADDR_EVENT)
      ev_clr = hwdata[5:0];
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) event_reg <= 6'h00;
    else         event_reg <= (event_reg & ~ev_clr) | event_set;
  end

  // ------------------------------------------------
  // role selection and dual-role toggling
  // ------------------------------------------------
  tccp_role_t role;
  assign role = tccp_role_t'(ctrl_reg[`TCCP_CTRL_ROLE_LO +: 2]);
  wire logic db_done = ctrl_reg[`TCCP_CTRL_DB_DONE];
  logic        drp_src_reg;
  logic [31:0] drp_cnt_reg;
  tccp_con_t   con_reg;

  // alternate role while unattached in dual-role mode
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      drp_src_reg <= 1'b0;
      drp_cnt_reg <= 32'h0;
    end else if (role != TCCP_ROLE_DRP || con_reg != TCCP_CON_NONE) begin
      drp_cnt_reg <= 32'h0;
    end else if (drp_cnt_reg >= drphalf_reg) begin
      drp_cnt_reg <= 32'h0;
      drp_src_reg <= ~drp_src_reg;
    end else begin
      drp_cnt_reg <= drp_cnt_reg + 32'h1;
    end
  end
  // dead battery forces sink until firmware releases it
  wire logic act_src = db_done &&
                       (role == TCCP_ROLE_SRC ||
                        (role == TCCP_ROLE_DRP && drp_src_reg));

  // ------------------------------------------------
  // attach classification and detach debounce
  // ------------------------------------------------
  tccp_con_t  con_next;
  logic [1:0] watch_reg;
  logic [1:0] watch_next;
  logic [31:0] deb_cnt_reg;
  logic [1:0] adv_reg;

  // source table decode
  always_comb begin
    con_next   = TCCP_CON_NONE;
    watch_next = 2'b11;
    if (act_src) begin
      unique case ({cc1_level, cc2_level})
        {TCCP_RD, TCCP_OPEN}: begin
          con_next = TCCP_CON_SINK; watch_next = 2'b01;
        end
        {TCCP_OPEN, TCCP_RD}: begin
          con_next = TCCP_CON_SINK; watch_next = 2'b10;
        end
        {TCCP_RA, TCCP_OPEN}: begin
          con_next = TCCP_CON_CABLE; watch_next = 2'b11;
        end
        {TCCP_OPEN, TCCP_RA}: begin
          con_next = TCCP_CON_CABLE; watch_next = 2'b11;
        end
        {TCCP_RA, TCCP_RD}: begin
          con_next = TCCP_CON_CBLSNK; watch_next = 2'b10;
        end
        {TCCP_RD, TCCP_RA}: begin
          con_next = TCCP_CON_CBLSNK; watch_next = 2'b01;
        end
        {TCCP_RD, TCCP_RD}: begin
          con_next = TCCP_CON_DEBUG; watch_next = 2'b11;
        end
        {TCCP_RA, TCCP_RA}: begin
          con_next = TCCP_CON_AUDIO; watch_next = 2'b11;
        end
        default: ;
      endcase
    end else if (flags.vbus_present) begin
      con_next = TCCP_CON_SOURCE;
    end
  end

  // detach when a watched pin is open; cable needs both pins open, source needs VBUS gone
  wire logic pin1_open = (cc1_level == TCCP_OPEN);
  wire logic pin2_open = (cc2_level == TCCP_OPEN);
  logic gone;
  always_comb begin
    unique case (con_reg)
      TCCP_CON_SOURCE: gone = !flags.vbus_present;
      TCCP_CON_CABLE:  gone = pin1_open && pin2_open;
      TCCP_CON_DEBUG,
      TCCP_CON_AUDIO:  gone = pin1_open || pin2_open;
      default:         gone = (watch_reg[0] && pin1_open) ||
                              (watch_reg[1] && pin2_open);
    endcase
  end

  // attach at once, detach after debounce of open pin or lost VBUS
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      con_reg     <= TCCP_CON_NONE;
      watch_reg   <= 2'b11;
      deb_cnt_reg <= 32'h0;
    end else if (con_reg == TCCP_CON_NONE ||
                 (con_reg == TCCP_CON_CABLE &&
                  con_next == TCCP_CON_CBLSNK)) begin
      con_reg     <= con_next;
      watch_reg   <= watch_next;
      deb_cnt_reg <= 32'h0;
    end else if (!gone) begin
      deb_cnt_reg <= 32'h0;
    end else if (deb_cnt_reg + 32'h1 >= ccdeb_reg) begin
      con_reg     <= TCCP_CON_NONE;
      watch_reg   <= 2'b11;
      deb_cnt_reg <= 32'h0;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 32'h1;
    end
  end

  // advertised current from the cc level
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) adv_reg <= 2'h0;
    else if (con_reg == TCCP_CON_SOURCE)
      adv_reg <= (cc1_level == TCCP_OPEN) ? cc2_level : cc1_level;
    else adv_reg <= 2'h0;
  end

  // ------------------------------------------------
  // sink gate protection timers
  // ------------------------------------------------
  wire logic gate_fault = flags.rev_cur || flags.bus_uv;
  logic [31:0] gate_cnt_reg;
  logic        gate_reg;
  // fault must persist block delay to open; clear must persist on delay
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gate_reg     <= 1'b0;
      gate_cnt_reg <= 32'h0;
    end else if (gate_reg == !gate_fault) begin
      gate_cnt_reg <= 32'h0;
    end else if (gate_cnt_reg + 32'h1 >=
                 (gate_reg ? blkdly_reg : ondly_reg)) begin
      gate_reg     <= ~gate_reg;
      gate_cnt_reg <= 32'h0;
    end else begin
      gate_cnt_reg <= gate_cnt_reg + 32'h1;
    end
  end

  // cable fault: count to fast-off then latch until fault clears
  wire logic cbl_fault = flags.cc_ov || flags.rev_5v;
  logic [31:0] cbl_cnt_reg;
  logic        cbl_off_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cbl_cnt_reg <= 32'h0;
      cbl_off_reg <= 1'b0;
    end else if (!cbl_fault) begin
      cbl_cnt_reg <= 32'h0;
      cbl_off_reg <= 1'b0;
    end else if (cbl_cnt_reg + 32'h1 >= fastoff_reg) begin
      cbl_off_reg <= 1'b1;
    end else begin
      cbl_cnt_reg <= cbl_cnt_reg + 32'h1;
    end
  end
  // overvoltage path bypasses the counter so switch drops at once
  wire logic cbl_kill = cbl_off_reg || flags.cc_ov;

  // ------------------------------------------------
  // power outputs
  // ------------------------------------------------
  wire logic src_pwr = con_reg == TCCP_CON_SINK ||
                       con_reg == TCCP_CON_CBLSNK;
  logic vbus_on_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) vbus_on_reg <= 1'b0;
    else         vbus_on_reg <= src_pwr;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pwr <= '0;
    end else begin
      pwr.bus_side_sink_gate     <= gate_reg && !act_src &&
                                    !gate_fault;
      pwr.bus_discharge_pulldown <= (con_reg == TCCP_CON_NONE);
      pwr.vbus_source_en         <= src_pwr;
      pwr.vconn_en[0] <= con_reg == TCCP_CON_CBLSNK && watch_reg == 2'b10
                         && !cbl_kill;
      pwr.vconn_en[1] <= con_reg == TCCP_CON_CBLSNK && watch_reg == 2'b01
                         && !cbl_kill;
      pwr.cable_power_switch <= con_reg == TCCP_CON_CBLSNK && !cbl_kill;
      pwr.sink_pulldown <= act_src ? 2'b00 : 2'b11;
      pwr.pullup_en     <= act_src ? 2'b11 : 2'b00;
      pwr.pullup_level  <= vbus_on_reg ?
                           ctrl_reg[`TCCP_CTRL_RP_LO +: 2] : 2'b00;
      pwr.pd_tx_en      <= ctrl_reg[`TCCP_CTRL_PD_EN] && !cbl_fault;
    end
  end

  // ------------------------------------------------
  // event detection
  // ------------------------------------------------
  tccp_con_t   con_d_reg;
  tccp_flags_t flags_d_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      con_d_reg   <= TCCP_CON_NONE;
      flags_d_reg <= '0;
    end else begin
      con_d_reg   <= con_reg;
      flags_d_reg <= flags;
    end
  end
  always_comb begin
    event_set[0] = con_d_reg == TCCP_CON_NONE && con_reg != TCCP_CON_NONE;
    event_set[1] = con_d_reg != TCCP_CON_NONE && con_reg == TCCP_CON_NONE;
    event_set[2] = flags.rev_cur != flags_d_reg.rev_cur;
    event_set[3] = flags.bus_uv  != flags_d_reg.bus_uv;
    event_set[4] = flags.cc_ov   != flags_d_reg.cc_ov;
    event_set[5] = flags.rev_5v  != flags_d_reg.rev_5v;
  end

  // ------------------------------------------------
  // bus read data
  // ------------------------------------------------
  logic [31:0] rd_next;
  always_comb begin
    unique case (haddr)
      `TCCP_ADDR_CTRL:    rd_next = ctrl_reg;
      `TCCP_ADDR_STATUS:  rd_next = {20'h0, strap_done, adv_reg, gate_reg,
                                     cbl_off_reg, watch_reg, act_src,
                                     1'b0, con_reg};
      `TCCP_ADDR_EVENT:   rd_next = {26'h0, event_reg};
      `TCCP_ADDR_STRAP:   rd_next = {26'h0, strap2_reg, strap1_reg};
      `TCCP_ADDR_BLKDLY:  rd_next = blkdly_reg;
      `TCCP_ADDR_ONDLY:   rd_next = ondly_reg;
      `TCCP_ADDR_CCDEB:   rd_next = ccdeb_reg;
      `TCCP_ADDR_FASTOFF: rd_next = fastoff_reg;
      `TCCP_ADDR_DRPHALF: rd_next = drphalf_reg;
      default:            rd_next = 32'h0;
    endcase
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      if (addr_ok && !hwrite) hrdata <= rd_next;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  wire logic unused_ok = &{1'b0, hsize, ctrl_reg[31:6], ctrl_reg[3]};
endmodule : tccp_top
`default_nettype wire

// [dv/tccp_far_end.sv]
`timescale 1ns/1ns
`default_nettype none
module tccp_far_end
  import tccp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // bench requests
  input  wire tccp_cc_t    cc1_want,
  input  wire tccp_cc_t    cc2_want,
  input  wire logic        is_source,
  input  wire logic [3:0]  faults,
  input  wire logic [13:0] strap_one,
  input  wire logic [13:0] strap_two,
  // device side
  input  wire tccp_pwr_t   pwr,
  input  wire logic        adc_sel_two,
  output var  tccp_cc_t    cc1_level,
  output var  tccp_cc_t    cc2_level,
  output var  tccp_flags_t flags,
  output var  logic        adc_valid,
  output var  logic [13:0] adc_ratio
);
  logic [1:0] adc_done;
  // a source partner powers the bus once it sees a sink pulldown
  always_ff @(posedge clock) begin
    cc1_level <= cc1_want;
    cc2_level <= cc2_want;
    flags     <= {faults, is_source & (|pwr.sink_pulldown)};
  end
  // one divider result per strap, strap one first
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      adc_done  <= 2'h0;
      adc_valid <= 1'b0;
      adc_ratio <= 14'h2AAA;
    end else begin
      adc_valid <= 1'b0;
      adc_ratio <= ~adc_ratio; // no stale value
      if (!adc_valid && adc_done != 2'h3 && adc_sel_two == adc_done[0]) begin
        adc_valid <= 1'b1;
        adc_ratio <= adc_sel_two ? strap_two : strap_one;
        adc_done  <= {adc_done[0], 1'b1};
      end
    end
  end
endmodule : tccp_far_end
`default_nettype wire

// [dv/tccp_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module tccp_monitor
  import tccp_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // watched ports
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire tccp_flags_t flags,
  input wire tccp_pwr_t   pwr
);
  // ------------------------------------------------
  // protection and power checks
  // ------------------------------------------------
  default clocking mcb @(posedge clock); endclocking
  default disable iff (sys_rst);
  rev_gate_off_a:
    assert property (flags.rev_cur |=> !pwr.bus_side_sink_gate)
    else $error("gate on in reverse");
  uv_gate_off_a:
    assert property (flags.bus_uv ##1 flags.bus_uv |-> !pwr.bus_side_sink_gate)
    else $error("gate on in undervoltage");
  ccov_cable_off_a:
    assert property (flags.cc_ov |=> !pwr.cable_power_switch)
    else $error("cable switch on in overvoltage");
  ccov_tx_off_a:
    assert property (flags.cc_ov |-> ##[1:4] !pwr.pd_tx_en)
    else $error("pd transmitter left on");
  vconn_single_a:
    assert property ($onehot0(pwr.vconn_en))
    else $error("vconn on both pins");
  vconn_with_bus_a:
    assert property (pwr.vconn_en != 2'h0 |-> pwr.vbus_source_en)
    else $error("vconn without bus power");
  no_drain_src_a:
    assert property (pwr.vbus_source_en |-> !pwr.bus_discharge_pulldown)
    else $error("discharge while sourcing");
  src_no_rd_a:
    assert property (pwr.vbus_source_en |-> pwr.sink_pulldown == 2'h0)
    else $error("sink pulldown while sourcing");
  rp_after_bus_a:
    assert property (pwr.pullup_level != 2'h0 && $past(pwr.pullup_level) == 2'h0
      |-> pwr.vbus_source_en || $past(pwr.vbus_source_en))
    else $error("pull-up level before bus power");
  bus_okay_a:
    assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  // main scenarios reached
  cover property ($rose(pwr.vbus_source_en));
  cover property (pwr.vconn_en != 2'h0);
  cover property ($fell(pwr.bus_side_sink_gate));
  cover property ($fell(pwr.pd_tx_en));
endmodule : tccp_monitor
`default_nettype wire

// [dv/test_typec_cc_attach_and_sink_protect.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tccp_consts.svh"
module test_typec_cc_attach_and_sink_protect;
  import tccp_pkg::*;
  // ------------------------------------------------
  // signals and tables
  // ------------------------------------------------
  logic        clock     = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic [1:0]  htrans    = 2'h0;
  logic [11:0] haddr     = 12'h000;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  tccp_cc_t    cc1_level;
  tccp_cc_t    cc2_level;
  tccp_cc_t    cc1_want  = TCCP_OPEN;
  tccp_cc_t    cc2_want  = TCCP_OPEN;
  tccp_flags_t flags;
  tccp_pwr_t   pwr;
  logic        adc_valid;
  logic        adc_sel_two;
  logic [13:0] adc_ratio;
  logic        is_source = 1'b0;
  logic [3:0]  faults    = 4'h0;
  logic [13:0] st1       = 14'hE58;
  logic [13:0] st2       = 14'h0;
  logic        rd_seen   = 1'b0;
  logic        p_seen    = 1'b0;
  logic [31:0] rd_val;
  logic [12:0] pv;
  logic [31:0] rq[$];
  logic [12:0] pq[$];
  logic [12:0] mq[$];
  logic [31:0] rs        = 32'h0001_5063;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  localparam logic [13:0] LB_TAB [8] = '{14'h0, 14'h0E5, 14'h2D3, 14'h591,
    14'h945, 14'hE58, 14'h1B99, 14'h2365};
  localparam logic [11:0] A_TAB [6] = '{`TCCP_ADDR_CTRL, `TCCP_ADDR_BLKDLY,
    `TCCP_ADDR_ONDLY, `TCCP_ADDR_CCDEB, `TCCP_ADDR_FASTOFF, `TCCP_ADDR_DRPHALF};
  localparam logic [31:0] V_TAB [6] = '{`TCCP_CTRL_RST, `TCCP_BLKDLY_RST,
    `TCCP_ONDLY_RST, `TCCP_CCDEB_RST, `TCCP_FASTOFF_RST, `TCCP_DRPHALF_RST};
  localparam tccp_cc_t C1_TAB [9] = '{TCCP_OPEN, TCCP_RD, TCCP_OPEN, TCCP_RA,
    TCCP_OPEN, TCCP_RA, TCCP_RD, TCCP_RD, TCCP_RA};
  localparam tccp_cc_t C2_TAB [9] = '{TCCP_OPEN, TCCP_OPEN, TCCP_RD, TCCP_OPEN,
    TCCP_RA, TCCP_RD, TCCP_RA, TCCP_RD, TCCP_RA};
  localparam tccp_con_t CON_TAB [9] = '{TCCP_CON_NONE, TCCP_CON_SINK,
    TCCP_CON_SINK, TCCP_CON_CABLE, TCCP_CON_CABLE, TCCP_CON_CBLSNK,
    TCCP_CON_CBLSNK, TCCP_CON_DEBUG, TCCP_CON_AUDIO};
  // bus power, vconn and pull-up level per case
  localparam logic [12:0] PW_TAB [9] = '{13'h0, 13'h402, 13'h402, 13'h0,
    13'h0, 13'h502, 13'h602, 13'h0, 13'h0};
  // ------------------------------------------------
  // design, partner, clock
  // ------------------------------------------------
  tccp_top uut (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cc1_level(cc1_level), .cc2_level(cc2_level),
    .flags(flags), .adc_valid(adc_valid), .adc_ratio(adc_ratio),
    .adc_sel_two(adc_sel_two), .pwr(pwr)
  );
  tccp_far_end far (
    .clock(clock), .sys_rst(sys_rst), .cc1_want(cc1_want),
    .cc2_want(cc2_want), .is_source(is_source), .faults(faults),
    .strap_one(st1), .strap_two(st2), .pwr(pwr), .adc_sel_two(adc_sel_two),
    .cc1_level(cc1_level), .cc2_level(cc2_level), .flags(flags),
    .adc_valid(adc_valid), .adc_ratio(adc_ratio)
  );
  always #2 clock = ~clock;
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  function automatic logic [2:0] code(input logic [13:0] r);
    logic [2:0] c;
    c = 3'h0;
    for (int k = 1; k < 8; k++) begin
      if (r >= LB_TAB[k]) c = 3'(k);
    end
    return c;
  endfunction : code
  // one ahb single transfer; reads queue their expectation
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] m);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    if (!w) begin
      rd_val  <= hrdata & m;
      rq.push_back(d & m);
      rd_seen <= 1'b1;
    end
  endtask : bus
  // extra edge: strobe never set twice in a step
  task automatic pchk(input logic [12:0] e, input logic [12:0] m);
    @(posedge clock);
    pv     <= pwr;
    pq.push_back(e);
    mq.push_back(m);
    p_seen <= 1'b1;
    @(posedge clock);
  endtask : pchk
  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] v);
    checks_done++;
    if (v !== e) begin
      bad_count++;
      $display("[ERR] hrdata expected %h seen %h", e, v);
    end
  endtask : cmp_reg
  task automatic cmp_pwr(input logic [12:0] e, m, v);
    checks_done++;
    if ((v & m) !== (e & m)) begin
      bad_count++;
      $display("[ERR] pwr expected %h seen %h", e & m, v & m);
    end
  endtask : cmp_pwr
  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // watcher: oldest note against each result
  always @(posedge clock) begin
    if (rd_seen) begin
      cmp_reg(rq.pop_front(), rd_val);
      rd_seen <= 1'b0;
    end
    if (p_seen) begin
      cmp_pwr(pq.pop_front(), mq.pop_front(), pv);
      p_seen <= 1'b0;
    end
  end
  // hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    int i;
    st2 = 14'(xs() % 32'h0000_2711);
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      bus(1'b0, A_TAB[i], V_TAB[i], 32'hFFFF_FFFF);
    end
    bus(1'b1, 12'h040, xs(), 32'h0);
    bus(1'b0, 12'h040, 32'h0, 32'hFFFF_FFFF);
    repeat (20) @(posedge clock);
    bus(1'b0, `TCCP_ADDR_STRAP, {26'h0, code(st2), code(st1)}, 32'h3F);
    bus(1'b0, `TCCP_ADDR_STATUS, 32'h800, 32'h800);
    pchk(13'h0860, 13'h0860);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 12'h010 + 12'(4 * i), 32'h4, 32'h0);
    end
    bus(1'b1, `TCCP_ADDR_CTRL, 32'h34, 32'h0);
    repeat (8) @(posedge clock);
    pchk(13'h0818, 13'h0F7E);
    // each source attach case, then a debounced detach
    for (i = 0; i < 9; i++) begin
      cc1_want <= C1_TAB[i];
      cc2_want <= C2_TAB[i];
      repeat (8) @(posedge clock);
      bus(1'b0, `TCCP_ADDR_STATUS, 32'(CON_TAB[i]), 32'h7);
      pchk(PW_TAB[i], 13'h0706);
      if (i == 1) begin
        bus(1'b0, `TCCP_ADDR_EVENT, 32'h1, 32'h1);
        cc1_want <= TCCP_OPEN;
        repeat (2) @(posedge clock);
        cc1_want <= TCCP_RD;
        repeat (10) @(posedge clock);
        bus(1'b0, `TCCP_ADDR_STATUS, 32'h1, 32'h7);
      end
      cc1_want <= TCCP_OPEN;
      cc2_want <= TCCP_OPEN;
      repeat (20) @(posedge clock);
      bus(1'b0, `TCCP_ADDR_STATUS, 32'h0, 32'h7);
      pchk(13'h0800, 13'h0F00);
    end
    // reverse current into local 5v, then cc overvoltage
    cc1_want <= TCCP_RA;
    cc2_want <= TCCP_RD;
    for (i = 0; i < 2; i++) begin
      repeat (8) @(posedge clock);
      faults <= i ? 4'h2 : 4'h1;
      repeat (8) @(posedge clock);
      pchk(13'h0000, 13'h0081);
      bus(1'b0, `TCCP_ADDR_EVENT, i ? 32'h10 : 32'h20, 32'h30);
      faults <= 4'h0;
      bus(1'b1, `TCCP_ADDR_EVENT, 32'h3F, 32'h0);
    end
    cc1_want <= TCCP_OPEN;
    cc2_want <= TCCP_OPEN;
    repeat (20) @(posedge clock);
    // sink role, powered source, then gate faults
    bus(1'b1, `TCCP_ADDR_CTRL, 32'h31, 32'h0);
    is_source <= 1'b1;
    cc1_want  <= TCCP_RP;
    repeat (12) @(posedge clock);
    bus(1'b0, `TCCP_ADDR_STATUS, 32'h606, 32'h607);
    pchk(13'h1060, 13'h1460);
    for (i = 0; i < 2; i++) begin
      faults <= i ? 4'h4 : 4'h8;
      repeat (3) @(posedge clock);
      pchk(13'h0000, 13'h1000);
      bus(1'b0, `TCCP_ADDR_EVENT, 32'h4 << i, 32'h4 << i);
      faults <= 4'h0;
      repeat (12) @(posedge clock);
      pchk(13'h1000, 13'h1000);
    end
    end_of_test();
  end
endmodule : test_typec_cc_attach_and_sink_protect
bind tccp_top tccp_monitor mon (
  .clock(clock), .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp),
  .flags(flags), .pwr(pwr)
);
`default_nettype wire

// [inc/tccp_consts.svh]
`ifndef TCCP_CONSTS_SVH
`define TCCP_CONSTS_SVH
// register byte addresses (32-bit aligned words)
`define TCCP_ADDR_CTRL      12'h000
`define TCCP_ADDR_STATUS    12'h004
`define TCCP_ADDR_EVENT     12'h008
`define TCCP_ADDR_STRAP     12'h00C
`define TCCP_ADDR_BLKDLY    12'h010
`define TCCP_ADDR_ONDLY     12'h014
`define TCCP_ADDR_CCDEB     12'h018
`define TCCP_ADDR_FASTOFF   12'h01C
`define TCCP_ADDR_DRPHALF   12'h020
// control field positions
`define TCCP_CTRL_ROLE_LO   0
`define TCCP_CTRL_RP_LO     2
`define TCCP_CTRL_DB_DONE   4
`define TCCP_CTRL_PD_EN     5
// reset values of delay counts, in core clock cycles, and of the control register
`define TCCP_BLKDLY_RST     32'h0000_00FA
`define TCCP_ONDLY_RST      32'h0000_09C4
`define TCCP_CCDEB_RST      32'h0000_1000
`define TCCP_FASTOFF_RST    32'h0000_0019
`define TCCP_DRPHALF_RST    32'h0000_1000
`define TCCP_CTRL_RST       32'h0000_0020
// strap ratio lower bounds, ratio scaled by 10000
`define TCCP_STRAP_B1       14'd229
`define TCCP_STRAP_B2       14'd723
`define TCCP_STRAP_B3       14'd1425
`define TCCP_STRAP_B4       14'd2373
`define TCCP_STRAP_B5       14'd3672
`define TCCP_STRAP_B6       14'd7065
`define TCCP_STRAP_B7       14'd9061
`endif

// [inc/tccp_pkg.sv]
package tccp_pkg;
  // cc pin termination class from the comparators
  typedef enum logic [1:0] {
    TCCP_OPEN, TCCP_RA, TCCP_RD, TCCP_RP
  } tccp_cc_t;
  typedef enum logic [1:0] {
    TCCP_ROLE_SRC, TCCP_ROLE_SNK, TCCP_ROLE_DRP, TCCP_ROLE_RSV
  } tccp_role_t;
  typedef enum logic [2:0] {
    TCCP_CON_NONE, TCCP_CON_SINK, TCCP_CON_CABLE, TCCP_CON_CBLSNK,
    TCCP_CON_DEBUG, TCCP_CON_AUDIO, TCCP_CON_SOURCE
  } tccp_con_t;
  // synchronized analog condition flags
  typedef struct packed {
    logic rev_cur;
    logic bus_uv;
    logic cc_ov;
    logic rev_5v;
    logic vbus_present;
  } tccp_flags_t;
  // power and termination controls to the analog front end
  typedef struct packed {
    logic       bus_side_sink_gate;
    logic       bus_discharge_pulldown;
    logic       vbus_source_en;
    logic [1:0] vconn_en;
    logic       cable_power_switch;
    logic [1:0] sink_pulldown;
    logic [1:0] pullup_en;
    logic [1:0] pullup_level;
    logic       pd_tx_en;
  } tccp_pwr_t;
endpackage : tccp_pkg
